/* sram_pkg.sv */
// shared constants, carriers and helpers of the burst-of-four sram command and start-up block
// assumes one 25 MHz system clock; the memory clocks arrive as plain pins and are sampled
package sram_pkg;

	localparam int DATA_W      = 18;
	localparam int ADDR_W      = 6;
	localparam int MEM_DEPTH   = 64;
	localparam int FIFO_DEPTH  = 16;
	localparam int BURST_LEN   = 4;

	// timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int CLK_STOP_NS   = 30;
	localparam int STOP_CYC_INT  = (CLK_STOP_NS / CLK_PERIOD_NS < 1) ? 1 : CLK_STOP_NS / CLK_PERIOD_NS;
	localparam logic [1:0] STOP_CYC = 2'(STOP_CYC_INT);
	localparam int LOCK_CYCLE_COUNT = 2048;
	localparam logic [11:0] LOCK_CNT_END = 12'(LOCK_CYCLE_COUNT);
	localparam logic [2:0] BURST_LEFT = 3'(BURST_LEN);
	localparam logic [2:0] WR_AFTER_FIRST = 3'(BURST_LEN - 1);

	typedef enum {INIT_IDLE, INIT_LOCK, INIT_READY} init_state_e;

	typedef struct packed {
		logic              vld;
		logic [ADDR_W-1:0] addr;
	} cmd_s;

	typedef struct packed {
		logic              vld;
		logic [DATA_W-1:0] data;
	} rword_s;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} beat_s;

	function automatic logic [ADDR_W-1:0] burst_addr(input logic [ADDR_W-1:0] base, input logic [1:0] beat);
		return base + {{(ADDR_W-2){1'b0}}, beat};
	endfunction

endpackage

/* burst_mem.sv */
// small single-port word memory with registered read data
// assumes at most one access per cycle; the caller arbitrates read against write
`timescale 1ns/1ns
module burst_mem #(
	parameter int W  = 18,
	parameter int AW = 6
) (
	input  wire logic          clk,
	input  wire logic          sys_rst,
	input  wire logic          en,
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [W-1:0]  wdata,
	output logic      [W-1:0]  rdata
);

	logic [W-1:0] mem_q [2**AW];
	logic [W-1:0] rdata_q;

	always_ff @(posedge clk) begin
		if (en && we) begin
			mem_q[addr] <= wdata;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_q <= '0;
		end else if (en && !we) begin
			rdata_q <= mem_q[addr];
		end
	end

	assign rdata = rdata_q;

endmodule // burst_mem

/* beat_fifo.sv */
// synchronous fifo with valid/ready on both sides
// assumes one clock; full and empty come from the pointer distance
`timescale 1ns/1ns
module beat_fifo #(
	parameter int W     = 24,
	parameter int DEPTH = 16
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);

	localparam int PW = $clog2(DEPTH);

	logic [W-1:0] store_q [DEPTH];
	logic [PW:0]  wr_ptr_q, wr_ptr_d;
	logic [PW:0]  rd_ptr_q, rd_ptr_d;
	logic         push, pop;

	always_comb begin
		in_ready  = (wr_ptr_q - rd_ptr_q) != (PW+1)'(DEPTH);
		out_valid = wr_ptr_q != rd_ptr_q;
		push      = in_valid && in_ready;
		pop       = out_valid && out_ready;
		wr_ptr_d  = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
		rd_ptr_d  = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			store_q[wr_ptr_q[PW-1:0]] <= in_data;
		end
	end

	assign out_data = store_q[rd_ptr_q[PW-1:0]];

endmodule // beat_fifo

/* ddr_burst4_sram_cmd_init.sv */
// command decode, burst-of-four timing and start-up readiness of a ddr sram with separate ports
// assumes the true and complementary clocks arrive as pins at clk/4; any slower clock trips the stop detection
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module ddr_burst4_sram_cmd_init (
	input  wire logic                        clk,
	input  wire logic                        sys_rst,
	input  wire logic                        k_pin,
	input  wire logic                        k_n_pin,
	input  wire logic                        dll_off_n,
	input  wire logic                        read_sel_n,
	input  wire logic                        write_sel_n,
	input  wire logic [sram_pkg::ADDR_W-1:0] addr_pin,
	input  wire logic [sram_pkg::DATA_W-1:0] din_pin,
	output logic      [sram_pkg::DATA_W-1:0] dout,
	output logic                             dout_oe_n,
	output logic                             data_valid,
	output logic                             device_ready,
	output logic                             dll_locked,
	output logic                             write_buf_ready
);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and filtered clock levels

	logic [2:0]                  k_sr_q, kn_sr_q, doff_sr_q, rs_sr_q, ws_sr_q;
	logic [sram_pkg::ADDR_W-1:0] addr_sr_q [3];
	logic [sram_pkg::DATA_W-1:0] din_sr_q  [3];
	logic                        k_lvl_q, k_lvl_d, kn_lvl_q, kn_lvl_d, doff_lvl_q, doff_lvl_d;
	logic [1:0]                  k_static_q, k_static_d, kn_static_q, kn_static_d;
	logic                        k_rise, kn_rise, half_edge, doff_rise, stop_hit;

	// a level counts once the second and third stages agree
	always_comb begin
		k_lvl_d     = (k_sr_q[1] == k_sr_q[2]) ? k_sr_q[2] : k_lvl_q;
		kn_lvl_d    = (kn_sr_q[1] == kn_sr_q[2]) ? kn_sr_q[2] : kn_lvl_q;
		doff_lvl_d  = (doff_sr_q[1] == doff_sr_q[2]) ? doff_sr_q[2] : doff_lvl_q;
		k_rise      = k_lvl_d && !k_lvl_q;
		kn_rise     = kn_lvl_d && !kn_lvl_q;
		half_edge   = k_rise || kn_rise;
		doff_rise   = doff_lvl_d && !doff_lvl_q;
		k_static_d  = (k_lvl_d != k_lvl_q) ? 2'h0 : k_static_q + {1'b0, k_static_q != 2'h3};
		kn_static_d = (kn_lvl_d != kn_lvl_q) ? 2'h0 : kn_static_q + {1'b0, kn_static_q != 2'h3};
		stop_hit    = (k_static_q > sram_pkg::STOP_CYC) || (kn_static_q > sram_pkg::STOP_CYC);
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			k_sr_q      <= 3'h0;
			kn_sr_q     <= 3'h7;
			doff_sr_q   <= 3'h0;
			rs_sr_q     <= 3'h7;
			ws_sr_q     <= 3'h7;
			addr_sr_q   <= '{default: '0};
			din_sr_q    <= '{default: '0};
			k_lvl_q     <= 1'b0;
			kn_lvl_q    <= 1'b1; // the complementary clock idles high, so no false edge follows reset
			doff_lvl_q  <= 1'b0;
			k_static_q  <= 2'h3;
			kn_static_q <= 2'h3;
		end else begin
			k_sr_q      <= {k_sr_q[1:0], k_pin};
			kn_sr_q     <= {kn_sr_q[1:0], k_n_pin};
			doff_sr_q   <= {doff_sr_q[1:0], dll_off_n};
			rs_sr_q     <= {rs_sr_q[1:0], read_sel_n};
			ws_sr_q     <= {ws_sr_q[1:0], write_sel_n};
			addr_sr_q   <= '{addr_pin, addr_sr_q[0], addr_sr_q[1]};
			din_sr_q    <= '{din_pin, din_sr_q[0], din_sr_q[1]};
			k_lvl_q     <= k_lvl_d;
			kn_lvl_q    <= kn_lvl_d;
			doff_lvl_q  <= doff_lvl_d;
			k_static_q  <= k_static_d;
			kn_static_q <= kn_static_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// start-up, loop reset and lock counting

	sram_pkg::init_state_e init_q, init_d;
	logic [11:0]           lock_cnt_q, lock_cnt_d;

	always_comb begin
		init_d     = init_q;
		lock_cnt_d = lock_cnt_q;
		if (stop_hit || doff_rise) begin
			init_d     = sram_pkg::INIT_IDLE;
			lock_cnt_d = 12'h000;
		end else begin
			case (init_q)
				sram_pkg::INIT_IDLE: begin
					if (k_rise) begin
						init_d     = sram_pkg::INIT_LOCK;
						lock_cnt_d = 12'h001;
					end
				end
				sram_pkg::INIT_LOCK: begin
					// same count with the loop bypassed, only the lock flag differs
					if (k_rise) begin
						lock_cnt_d = lock_cnt_q + 12'h001;
						if (lock_cnt_q == sram_pkg::LOCK_CNT_END - 12'h001) begin
							init_d = sram_pkg::INIT_READY;
						end
					end
				end
				sram_pkg::INIT_READY: begin
					init_d = sram_pkg::INIT_READY;
				end
				default: begin
					init_d = sram_pkg::INIT_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			init_q     <= sram_pkg::INIT_IDLE;
			lock_cnt_q <= 12'h000;
		end else begin
			init_q     <= init_d;
			lock_cnt_q <= lock_cnt_d;
		end
	end

	assign device_ready = init_q == sram_pkg::INIT_READY;
	assign dll_locked   = device_ready && doff_lvl_q;

	////////////////////////////////////////////////////////////////////////////////
	// command decode on the true clock

	logic rd_go, wr_go, rd_prev_q, rd_prev_d, wr_prev_q, wr_prev_d, nop_prev_q, nop_prev_d;
	logic rd_req, wr_req;

	always_comb begin
		rd_req     = k_rise && device_ready && !rs_sr_q[2];
		wr_req     = k_rise && device_ready && !ws_sr_q[2];
		rd_go      = rd_req && !rd_prev_q;
		wr_go      = wr_req && !wr_prev_q && !(rd_req && nop_prev_q);
		rd_prev_d  = k_rise ? rd_go : rd_prev_q;
		wr_prev_d  = k_rise ? wr_go : wr_prev_q;
		nop_prev_d = k_rise ? (rs_sr_q[2] && ws_sr_q[2]) : nop_prev_q;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_prev_q  <= 1'b0;
			wr_prev_q  <= 1'b0;
			nop_prev_q <= 1'b1;
		end else begin
			rd_prev_q  <= rd_prev_d;
			wr_prev_q  <= wr_prev_d;
			nop_prev_q <= nop_prev_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read burst: one word fetched per half edge, shown four half edges later

	logic [2:0]                  rd_left_q, rd_left_d;
	logic [1:0]                  rd_beat_q, rd_beat_d;
	logic [sram_pkg::ADDR_W-1:0] rd_base_q, rd_base_d;
	logic                        tok_q, tok_d, tok_new;
	sram_pkg::rword_s            pipe_q [3];
	sram_pkg::rword_s            pipe_d [3];
	logic [sram_pkg::DATA_W-1:0] dout_q, dout_d, mem_rdata;
	logic                        oe_n_q, oe_n_d;

	always_comb begin
		rd_left_d = rd_left_q;
		rd_beat_d = rd_beat_q;
		rd_base_d = rd_base_q;
		tok_d     = tok_q;
		pipe_d    = pipe_q;
		dout_d    = dout_q;
		oe_n_d    = oe_n_q;
		tok_new   = half_edge && (rd_left_q != 3'h0);
		// outputs only move on clock edges, so a stopped clock freezes them
		if (half_edge) begin
			tok_d     = tok_new;
			pipe_d[0] = '{vld: tok_q, data: mem_rdata};
			pipe_d[1] = pipe_q[0];
			pipe_d[2] = pipe_q[1];
			oe_n_d    = !pipe_q[2].vld;
			if (pipe_q[2].vld) begin
				dout_d = pipe_q[2].data;
			end
			if (tok_new) begin
				rd_left_d = rd_left_q - 3'h1;
				rd_beat_d = rd_beat_q + 2'h1;
			end
		end
		if (rd_go) begin
			rd_left_d = sram_pkg::BURST_LEFT;
			rd_beat_d = 2'h0;
			rd_base_d = addr_sr_q[2];
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_left_q <= 3'h0;
			rd_beat_q <= 2'h0;
			rd_base_q <= '0;
			tok_q     <= 1'b0;
			pipe_q    <= '{default: '0};
			dout_q    <= '0;
			oe_n_q    <= 1'b1;
		end else begin
			rd_left_q <= rd_left_d;
			rd_beat_q <= rd_beat_d;
			rd_base_q <= rd_base_d;
			tok_q     <= tok_d;
			pipe_q    <= pipe_d;
			dout_q    <= dout_d;
			oe_n_q    <= oe_n_d;
		end
	end

	assign dout       = dout_q;
	assign dout_oe_n  = oe_n_q;
	assign data_valid = !oe_n_q;

	////////////////////////////////////////////////////////////////////////////////
	// late write: four beats from the second half edge after the command

	sram_pkg::cmd_s              ws_q [2];
	sram_pkg::cmd_s              ws_d [2];
	logic [2:0]                  wcap_left_q, wcap_left_d;
	logic [1:0]                  wcap_beat_q, wcap_beat_d;
	logic [sram_pkg::ADDR_W-1:0] wcap_base_q, wcap_base_d;
	logic                        cap_valid;
	sram_pkg::beat_s             cap_beat, drain_beat;

	always_comb begin
		ws_d        = ws_q;
		wcap_left_d = wcap_left_q;
		wcap_beat_d = wcap_beat_q;
		wcap_base_d = wcap_base_q;
		cap_valid   = 1'b0;
		cap_beat    = '{addr: sram_pkg::burst_addr(wcap_base_q, wcap_beat_q), data: din_sr_q[2]};
		if (half_edge) begin
			ws_d[0] = '{vld: wr_go, addr: addr_sr_q[2]};
			ws_d[1] = ws_q[0];
			if (ws_q[1].vld) begin
				cap_valid   = 1'b1;
				cap_beat    = '{addr: ws_q[1].addr, data: din_sr_q[2]};
				wcap_left_d = sram_pkg::WR_AFTER_FIRST;
				wcap_beat_d = 2'h1;
				wcap_base_d = ws_q[1].addr;
			end else if (wcap_left_q != 3'h0) begin
				cap_valid   = 1'b1;
				wcap_left_d = wcap_left_q - 3'h1;
				wcap_beat_d = wcap_beat_q + 2'h1;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ws_q        <= '{default: '0};
			wcap_left_q <= 3'h0;
			wcap_beat_q <= 2'h0;
			wcap_base_q <= '0;
		end else begin
			ws_q        <= ws_d;
			wcap_left_q <= wcap_left_d;
			wcap_beat_q <= wcap_beat_d;
			wcap_base_q <= wcap_base_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// write buffer and array; reads take the port first, so the buffer can back up

	logic drain_valid, drain_ready, mem_rd_en;

	assign mem_rd_en   = tok_new;
	assign drain_ready = !mem_rd_en;

	beat_fifo #(
		.W     ($bits(sram_pkg::beat_s)),
		.DEPTH (sram_pkg::FIFO_DEPTH)
	) u_wbuf (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.in_valid  (cap_valid),
		.in_ready  (write_buf_ready),
		.in_data   (cap_beat),
		.out_valid (drain_valid),
		.out_ready (drain_ready),
		.out_data  (drain_beat)
	);

	burst_mem #(
		.W  (sram_pkg::DATA_W),
		.AW (sram_pkg::ADDR_W)
	) u_array (
		.clk     (clk),
		.sys_rst (sys_rst),
		.en      (mem_rd_en || drain_valid),
		.we      (!mem_rd_en),
		.addr    (mem_rd_en ? sram_pkg::burst_addr(rd_base_q, rd_beat_q) : drain_beat.addr),
		.wdata   (drain_beat.data),
		.rdata   (mem_rdata)
	);

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	chk_no_cmd_early: assert property (!device_ready |-> !rd_go && !wr_go)
		else $error("command accepted before ready");
	chk_bypass_unlocked: assert property (!doff_lvl_q |-> !dll_locked)
		else $error("lock flag with loop bypassed");
	chk_stop_relock: assert property (stop_hit |=> !device_ready && lock_cnt_q == 12'h000)
		else $error("static clock did not reset the loop");
	chk_doff_relock: assert property (doff_rise |=> !device_ready && lock_cnt_q == 12'h000)
		else $error("dll disable rise did not reset the loop");
	chk_lock_length: assert property ($rose(device_ready) |-> lock_cnt_q == sram_pkg::LOCK_CNT_END)
		else $error("ready after wrong lock count");
	chk_burst_linear: assert property (tok_new && !rd_go |=> rd_beat_q == $past(rd_beat_q) + 2'h1)
		else $error("read burst address not linear");
	chk_read_decode: assert property (k_rise && device_ready && !rs_sr_q[2] && !rd_prev_q |-> rd_go)
		else $error("read request missed");
	chk_write_decode: assert property (k_rise && device_ready && !ws_sr_q[2] && !wr_prev_q && rs_sr_q[2] |-> wr_go)
		else $error("write request missed");
	chk_second_ignored: assert property (k_rise && rd_prev_q |-> !rd_go)
		else $error("back to back read accepted");
	chk_write_dropped: assert property (k_rise && nop_prev_q && !rs_sr_q[2] && !ws_sr_q[2] |-> !wr_go)
		else $error("write kept beside read after no-op");
	chk_read_drive: assert property (half_edge && pipe_q[2].vld |=> !dout_oe_n && dout == $past(pipe_q[2].data))
		else $error("read word not driven");
	chk_idle_float: assert property (half_edge && !pipe_q[2].vld |=> dout_oe_n)
		else $error("outputs driven without a read word");
	chk_hold_stopped: assert property (!half_edge |=> $stable(dout) && $stable(dout_oe_n))
		else $error("outputs moved without a clock edge");
	chk_write_first: assert property (half_edge && ws_q[1].vld |-> cap_valid ##1 wcap_left_q == 3'h3)
		else $error("first write beat not captured");

	cov_read:    cover property (rd_go);
	cov_both:    cover property (rd_go && wr_go);
	cov_blocked: cover property (wr_req && rd_req && nop_prev_q);
	cov_full:    cover property (!write_buf_ready);

endmodule // ddr_burst4_sram_cmd_init

/* sram_ctrl_model.sv */
// memory controller model: true and complementary clocks, selects, address and late-write data
// assumes clk at 25 MHz; one true clock period is four clk cycles, run low stops both clocks
`timescale 1ns/1ns
module sram_ctrl_model (
	input  wire logic                        clk,
	input  wire logic                        run,
	input  wire logic                        rd_req,
	input  wire logic                        wr_req,
	input  wire logic [sram_pkg::ADDR_W-1:0] req_addr,
	input  wire logic [sram_pkg::DATA_W-1:0] req_data,
	output logic                             k_pin,
	output logic                             k_n_pin,
	output logic                             read_sel_n,
	output logic                             write_sel_n,
	output logic      [sram_pkg::ADDR_W-1:0] addr_pin,
	output logic      [sram_pkg::DATA_W-1:0] din_pin,
	output logic                             k_rise
);
	logic [1:0]                ph_q;
	logic                      wr_last_q;
	logic [sram_pkg::DATA_W:0] sh_q [0:12];

	////////////////////////////////////////////////////////////////////////////////
	// every pin at a defined level from time zero
	initial begin
		ph_q = 2'h0;
		wr_last_q = 1'b0;
		k_pin = 1'b0;
		k_n_pin = 1'b1;
		k_rise = 1'b0;
		read_sel_n = 1'b1;
		write_sel_n = 1'b1;
		addr_pin = 6'h00;
		din_pin = 18'h00000;
		for (int i = 0; i < 13; i++)
			sh_q[i] = 19'h00000;
	end

	////////////////////////////////////////////////////////////////////////////////
	// selects change at the true clock fall so they stand still around the rise
	always @(posedge clk) begin
		k_rise <= run && ph_q == 2'h3;
		if (run) begin
			ph_q <= ph_q + 2'h1;
			k_pin <= ph_q == 2'h3 || ph_q == 2'h0;
			k_n_pin <= !(ph_q == 2'h3 || ph_q == 2'h0);
			if (ph_q == 2'h1) begin
				read_sel_n <= !rd_req;
				write_sel_n <= !wr_req;
				addr_pin <= (rd_req || wr_req) ? req_addr : ~addr_pin;
			end
			for (int i = 0; i < 12; i++)
				sh_q[i] <= sh_q[i + 1];
			sh_q[12] <= 19'h00000;
			if (ph_q == 2'h3) begin
				wr_last_q <= !write_sel_n && !wr_last_q;
				// a write on the next rise after an accepted one gets no data
				if (!write_sel_n && !wr_last_q) begin
					for (int n = 0; n < 4; n++)
						sh_q[3 + 2 * n] <= {1'b1, req_data + 18'(n)};
				end
			end
			// unused data cycles carry the inverse of the previous cycle's pins, so a second idle cycle repeats the last word
			din_pin <= sh_q[0][sram_pkg::DATA_W] ? sh_q[0][sram_pkg::DATA_W-1:0] : ~din_pin;
		end
	end
endmodule // sram_ctrl_model

/* ddr_burst4_sram_cmd_init_test.sv */
// self-checking bench of the burst-of-four sram command and start-up block
// assumes the controller model makes the memory clocks at one quarter of clk
`timescale 1ns/1ns
module ddr_burst4_sram_cmd_init_test;
	typedef logic [sram_pkg::DATA_W-1:0] word_t;
	typedef logic [sram_pkg::ADDR_W-1:0] adr_t;
	typedef struct packed {
		adr_t  waddr;
		word_t wdata;
		adr_t  raddr;
		word_t ex0;
	} row_s;

	localparam int LIMIT = 40000;
	logic  clk = 1'b0;
	logic  sys_rst = 1'b1;
	logic  run = 1'b0;
	logic  dll_off_n = 1'b0;
	logic  rd_req = 1'b0;
	logic  wr_req = 1'b0;
	adr_t  req_addr = 6'h00;
	word_t req_data = 18'h00000;
	logic  k_pin, k_n_pin, read_sel_n, write_sel_n, k_rise;
	adr_t  addr_pin;
	word_t din_pin, dout, last_dout;
	logic  dout_oe_n, data_valid, device_ready, dll_locked, write_buf_ready;
	word_t mem_exp [0:63];
	int    mismatches = 0;
	int    samples_checked = 0;
	int    cycles = 0;
	int    kr_cnt = 0;
	// third row reads from the bottom of the array: 00 and 01 come from the 3E burst, which wraps across the top
	row_s  rows [4] = '{'{6'h04, 18'h12340, 6'h04, 18'h12340}, '{6'h3E, 18'h0ABC0, 6'h3E, 18'h0ABC0},
		'{6'h02, 18'h20000, 6'h00, 18'h0ABC2}, '{6'h21, 18'h3FFF0, 6'h21, 18'h3FFF0}};

	sram_ctrl_model sram_ctrl_model_i (.clk(clk), .run(run), .rd_req(rd_req), .wr_req(wr_req),
		.req_addr(req_addr), .req_data(req_data), .k_pin(k_pin), .k_n_pin(k_n_pin),
		.read_sel_n(read_sel_n), .write_sel_n(write_sel_n), .addr_pin(addr_pin), .din_pin(din_pin),
		.k_rise(k_rise));
	ddr_burst4_sram_cmd_init ddr_burst4_sram_cmd_init_i (.clk(clk), .sys_rst(sys_rst), .k_pin(k_pin),
		.k_n_pin(k_n_pin), .dll_off_n(dll_off_n), .read_sel_n(read_sel_n), .write_sel_n(write_sel_n),
		.addr_pin(addr_pin), .din_pin(din_pin), .dout(dout), .dout_oe_n(dout_oe_n),
		.data_valid(data_valid), .device_ready(device_ready), .dll_locked(dll_locked),
		.write_buf_ready(write_buf_ready));

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #20 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (k_rise)
			kr_cnt <= kr_cnt + 1;
		if (cycles == LIMIT) begin
			mismatches++;
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checked %0d values, %0d wrong", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input word_t got, input word_t want);
		samples_checked++;
		if (got !== want) begin
			mismatches++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, want);
		end
	endtask

	// one true clock period per call; the request lands on the next rise
	task automatic cmd(input logic r, input logic w, input adr_t a, input word_t d);
		do @(posedge clk); while (k_rise !== 1'b1);
		rd_req <= r;
		wr_req <= w;
		req_addr <= a;
		req_data <= d;
	endtask

	task automatic idle(input int n);
		repeat (n) cmd(1'b0, 1'b0, 6'h00, 18'h00000);
	endtask

	task automatic setmem(input adr_t a, input word_t d);
		for (int n = 0; n < 4; n++)
			mem_exp[a + adr_t'(n)] = d + word_t'(n);
	endtask

	// waits for the first word, then takes one word per half edge
	task automatic collect(input adr_t a, input int lat, input word_t ex0);
		int i;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (data_valid !== 1'b1 && i < 40);
		chk(18'(i >= lat - 1 && i <= lat + 1), 18'h00001);
		for (int n = 0; n < 4; n++) begin
			chk(dout, n == 0 ? ex0 : mem_exp[a + adr_t'(n)]);
			repeat (2) @(posedge clk);
		end
		@(posedge clk);
		chk(18'(dout_oe_n), 18'h00001);
	endtask

	task automatic wr(input adr_t a, input word_t d);
		cmd(1'b0, 1'b1, a, d);
		setmem(a, d);
		idle(6);
	endtask

	task automatic rd(input adr_t a, input word_t ex0);
		cmd(1'b1, 1'b0, a, 18'h00000);
		idle(1);
		collect(a, 14, ex0);
		idle(2);
	endtask

	// readiness is counted in true clock rises; a read seen meanwhile is a fault
	task automatic wait_ready();
		int   k0;
		logic early;
		k0 = kr_cnt;
		early = 1'b0;
		while (device_ready !== 1'b1) begin
			@(posedge clk);
			if (data_valid === 1'b1)
				early = 1'b1;
		end
		chk(18'(kr_cnt - k0 >= 2047 && kr_cnt - k0 <= 2050), 18'h00001);
		chk(18'(early), 18'h00000);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		run <= 1'b1;
		cmd(1'b1, 1'b0, 6'h04, 18'h00000);
		idle(1);
		wait_ready();
		chk(18'(dll_locked), 18'h00000);
		chk(18'(dout_oe_n), 18'h00001);
		chk(18'(write_buf_ready), 18'h00001);
		$display("test start-up done");
		foreach (rows[j]) begin
			wr(rows[j].waddr, rows[j].wdata);
			rd(rows[j].raddr, rows[j].ex0);
		end
		$display("test table done");
		cmd(1'b0, 1'b1, 6'h04, 18'h15550);
		setmem(6'h04, 18'h15550);
		cmd(1'b0, 1'b1, 6'h21, 18'h2AAA0);
		idle(6);
		rd(6'h21, 18'h3FFF0);
		rd(6'h04, 18'h15550);
		$display("test back-to-back done");
		cmd(1'b1, 1'b1, 6'h04, 18'h1F00F);
		idle(1);
		collect(6'h04, 14, 18'h15550);
		idle(4);
		rd(6'h04, 18'h15550);
		$display("test both selects done");
		cmd(1'b1, 1'b0, 6'h3E, 18'h00000);
		cmd(1'b0, 1'b1, 6'h30, 18'h2468A);
		setmem(6'h30, 18'h2468A);
		idle(1);
		collect(6'h3E, 10, 18'h0ABC0);
		idle(4);
		rd(6'h30, 18'h2468A);
		$display("test overlap done");
		dll_off_n <= 1'b1;
		repeat (6) @(posedge clk);
		chk(18'(device_ready), 18'h00000);
		wait_ready();
		chk(18'(dll_locked), 18'h00001);
		rd(6'h02, 18'h20000);
		$display("test loop enable done");
		last_dout = dout;
		run <= 1'b0;
		repeat (8) @(posedge clk);
		chk(18'(device_ready), 18'h00000);
		chk(dout, last_dout);
		chk(18'(dout_oe_n), 18'h00001);
		run <= 1'b1;
		wait_ready();
		rd(6'h04, 18'h15550);
		$display("test clock stop done");
		end_of_test();
	end
endmodule // ddr_burst4_sram_cmd_init_test
